// ### lvts_defs.vh
// constants for the lcd vertical timing and screen address block
`ifndef LVTS_DEFS_VH
`define LVTS_DEFS_VH
// register indices; the byte address is four times the index
`define LVTS_IDX_VBLANK     8'h0a
`define LVTS_IDX_ACRATE     8'h0b
`define LVTS_IDX_S1_LO      8'h0c
`define LVTS_IDX_S1_HI      8'h0d
`define LVTS_IDX_S2_LO      8'h0e
`define LVTS_IDX_S2_HI      8'h0f
`define LVTS_IDX_TOPBIT     8'h10
`define LVTS_IDX_LOFS       8'h11
`define LVTS_IDX_S1H_LO     8'h12
`define LVTS_IDX_S1H_HI     8'h13
`define LVTS_IDX_IRQ_STAT   8'h20
`define LVTS_IDX_IRQ_EN     8'h21
`define LVTS_IDX_IRQ_CLR    8'h22
`define LVTS_IDX_CTRL       8'h23
// field positions
`define LVTS_VB_FLAG_BIT    7
`define LVTS_CTRL_ROT_BIT   0
`define LVTS_CTRL_PAS_BIT   1
`define LVTS_CTRL_EN_BIT    2
// reset values
`define LVTS_RST_VBLANK     6'h00
`define LVTS_RST_ACRATE     6'h00
`define LVTS_RST_CTRL       3'h2
`define LVTS_RST_S1H        10'h3ff
`define LVTS_RST_PANEL      10'h0ef
// axi responses
`define LVTS_RESP_OKAY      2'h0
`define LVTS_RESP_SLVERR    2'h2
// interrupt status bits
`define LVTS_IRQ_VB_START   0
`define LVTS_IRQ_FRAME      1
`define LVTS_IRQ_W          2
`endif

// ### lvts_top.v
// lcd vertical timing, ac modulation and screen start address logic
//
// Overview of operation
// - top bit of the vertical non-display register reads one during blanking.
// - vertical non-display lasts exactly the six-bit period field in lines.
// - rate field zero toggles ac modulation output on every frame pulse.
// - nonzero rate field toggles ac modulation after field plus one line pulses.
// - modulation rate applies only to passive panels, none for active matrix.
// - screen 1 start is a word address landscape, byte address rotated.
// - overflow bit 0 is screen 1 address bit 16, rotated mode only.
// - screen 2 start is used in landscape only, ignored when rotated.
// - landscape adds eight-bit word offset between line end and next line start.
// - nonzero line offset makes a virtual image wider than the panel.
// - line offset ignored in rotated modes; line byte count governs there.
// - screen 1 on lines zero to n, screen 2 on the rest.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "lvts_defs.vh"

module lvts_top
(
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // timing from the controller core
  input  wire        line_pulse,
  input  wire        frame_pulse,
  input  wire [9:0]  panel_last_line,
  // panel and fetch side
  output reg         ac_modulation_output,
  output reg         vblank_active,
  output reg         lower_screen_sel,
  output reg  [16:0] screen_start_addr,
  output reg  [7:0]  line_offset_words,
  // interrupt
  output reg         irq
);
  // ==========================================================
  // register storage
  reg [5:0]  vblank_period_r;
  reg [5:0]  ac_rate_r;
  reg [15:0] s1_start_r;
  reg [15:0] s2_start_r;
  reg        s1_top_bit_r;
  reg [7:0]  line_ofs_r;
  reg [9:0]  s1_height_r;
  reg [2:0]  ctrl_r;
  reg [1:0]  irq_stat_r;
  reg [1:0]  irq_en_r;
  wire rotated = ctrl_r[`LVTS_CTRL_ROT_BIT];
  wire passive = ctrl_r[`LVTS_CTRL_PAS_BIT];
  wire run     = ctrl_r[`LVTS_CTRL_EN_BIT];
  // ==========================================================
  // axi write channel
  reg        aw_held_r;
  reg        w_held_r;
  reg [7:0]  aw_addr_r;
  reg [31:0] w_data_r;
  reg        w_lane0_r;
  wire [7:0] aw_eff   = aw_held_r ? aw_addr_r : s_axi_awaddr;
  wire [31:0] w_eff   = w_held_r ? w_data_r : s_axi_wdata;
  wire       lane0    = w_held_r ? w_lane0_r : s_axi_wstrb[0];
  wire       aw_have  = aw_held_r | (s_axi_awvalid & s_axi_awready);
  wire       w_have   = w_held_r | (s_axi_wvalid & s_axi_wready);
  wire       do_write = aw_have & w_have & ~s_axi_bvalid;
  wire [5:0] wr_idx   = aw_eff[7:2];
  wire       wr_mapped = (wr_idx >= `LVTS_IDX_VBLANK) && (wr_idx <= `LVTS_IDX_CTRL) &&
                         !((wr_idx > `LVTS_IDX_S1H_HI) && (wr_idx < `LVTS_IDX_IRQ_STAT));
  wire       wr_en    = do_write & lane0;
  wire       clr_wr   = wr_en && wr_idx == `LVTS_IDX_IRQ_CLR;

  // address and data are accepted independently, one write in flight
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `LVTS_RESP_OKAY;
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h00000000;
      w_lane0_r     <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_data_r  <= s_axi_wdata;
        w_lane0_r <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `LVTS_RESP_OKAY : `LVTS_RESP_SLVERR;
      end
      else
      begin
        aw_held_r <= aw_have;
        w_held_r  <= w_have;
      end
      if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      // ready low while a half is parked or the response waits
      s_axi_awready <= ~aw_have & ~s_axi_bvalid & ~do_write & ~s_axi_awready;
      s_axi_wready  <= ~w_have & ~s_axi_bvalid & ~do_write & ~s_axi_wready;
    end
  end

  // ==========================================================
  // register writes; only byte lane 0 carries data
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      vblank_period_r <= `LVTS_RST_VBLANK;
      ac_rate_r       <= `LVTS_RST_ACRATE;
      s1_start_r      <= 16'h0000;
      s2_start_r      <= 16'h0000;
      s1_top_bit_r    <= 1'b0;
      line_ofs_r      <= 8'h00;
      s1_height_r     <= `LVTS_RST_S1H;
      ctrl_r          <= `LVTS_RST_CTRL;
      irq_en_r        <= 2'h0;
    end
    else if (wr_en)
    begin
      case (wr_idx)
        `LVTS_IDX_VBLANK:  vblank_period_r   <= w_eff[5:0]; // status bit is not writable
        `LVTS_IDX_ACRATE:  ac_rate_r         <= w_eff[5:0];
        `LVTS_IDX_S1_LO:   s1_start_r[7:0]   <= w_eff[7:0];
        `LVTS_IDX_S1_HI:   s1_start_r[15:8]  <= w_eff[7:0];
        `LVTS_IDX_S2_LO:   s2_start_r[7:0]   <= w_eff[7:0];
        `LVTS_IDX_S2_HI:   s2_start_r[15:8]  <= w_eff[7:0];
        `LVTS_IDX_TOPBIT:  s1_top_bit_r      <= w_eff[0];
        `LVTS_IDX_LOFS:    line_ofs_r        <= w_eff[7:0];
        `LVTS_IDX_S1H_LO:  s1_height_r[7:0]  <= w_eff[7:0];
        `LVTS_IDX_S1H_HI:  s1_height_r[9:8]  <= w_eff[1:0];
        `LVTS_IDX_IRQ_EN:  irq_en_r          <= w_eff[1:0];
        `LVTS_IDX_CTRL:    ctrl_r            <= w_eff[2:0];
        default:           ctrl_r            <= ctrl_r;
      endcase
    end
  end

  // ==========================================================
  // line counter and vertical non-display period
  reg [9:0] line_cnt_r;
  reg [5:0] vb_cnt_r;
  reg       in_vb_r;
  // active lines run to panel_last_line, then exactly period lines of blanking
  // a zero period gives no blanking at all
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      line_cnt_r <= 10'h000;
      vb_cnt_r   <= 6'h00;
      in_vb_r    <= 1'b0;
    end
    else if (!run)
    begin
      line_cnt_r <= 10'h000;
      vb_cnt_r   <= 6'h00;
      in_vb_r    <= 1'b0;
    end
    else if (line_pulse)
    begin
      if (in_vb_r)
      begin
        if (vb_cnt_r == vblank_period_r - 6'h01)
        begin
          in_vb_r    <= 1'b0;
          line_cnt_r <= 10'h000;
        end
        vb_cnt_r <= vb_cnt_r + 6'h01;
      end
      else if (line_cnt_r == panel_last_line)
      begin
        line_cnt_r <= 10'h000;
        vb_cnt_r   <= 6'h00;
        in_vb_r    <= (vblank_period_r != 6'h00);
      end
      else
      begin
        line_cnt_r <= line_cnt_r + 10'h001;
      end
    end
  end

  // ==========================================================
  // ac modulation toggle, passive panels only
  reg [5:0] ac_cnt_r;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ac_cnt_r             <= 6'h00;
      ac_modulation_output <= 1'b0;
    end
    else if (!passive)
    begin
      // held low: no meaning on active matrix panels
      ac_cnt_r             <= 6'h00;
      ac_modulation_output <= 1'b0;
    end
    else if (ac_rate_r == 6'h00)
    begin
      ac_cnt_r <= 6'h00;
      if (frame_pulse)
      begin
        ac_modulation_output <= ~ac_modulation_output;
      end
    end
    else if (line_pulse)
    begin
      if (ac_cnt_r >= ac_rate_r)
      begin
        ac_cnt_r             <= 6'h00;
        ac_modulation_output <= ~ac_modulation_output;
      end
      else
      begin
        ac_cnt_r <= ac_cnt_r + 6'h01;
      end
    end
  end

  // ==========================================================
  // screen selection and start address outputs
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      vblank_active     <= 1'b0;
      lower_screen_sel  <= 1'b0;
      screen_start_addr <= 17'h00000;
      line_offset_words <= 8'h00;
    end
    else
    begin
      vblank_active <= in_vb_r;
      // split only in landscape; rotated always shows screen 1
      lower_screen_sel <= ~rotated & ~in_vb_r & (line_cnt_r > s1_height_r);
      if (rotated)
      begin
        screen_start_addr <= {s1_top_bit_r, s1_start_r}; // byte address
      end
      else if (~in_vb_r & (line_cnt_r > s1_height_r))
      begin
        screen_start_addr <= {1'b0, s2_start_r};
      end
      else
      begin
        screen_start_addr <= {1'b0, s1_start_r}; // word address
      end
      // offset forms a virtual image; none in rotated mode
      line_offset_words <= rotated ? 8'h00 : line_ofs_r;
    end
  end

  // ==========================================================
  // interrupt status: set beats clear in the same cycle
  reg  in_vb_d_r;
  wire [1:0] irq_set = {frame_pulse, in_vb_r & ~in_vb_d_r};
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      in_vb_d_r  <= 1'b0;
      irq_stat_r <= 2'h0;
      irq        <= 1'b0;
    end
    else
    begin
      in_vb_d_r  <= in_vb_r;
      irq_stat_r <= (irq_stat_r & ~(clr_wr ? w_eff[1:0] : 2'h0)) | irq_set;
      irq        <= |(irq_stat_r & irq_en_r);
    end
  end

  // ==========================================================
  // axi read channel, answer one cycle after the address
  wire [5:0] rd_idx = s_axi_araddr[7:2];
  reg  [7:0] rd_byte;
  reg        rd_ok;
  always @*
  begin
    rd_byte = 8'h00;
    rd_ok   = 1'b1;
    case (rd_idx)
      `LVTS_IDX_VBLANK:   rd_byte = {in_vb_r, 1'b0, vblank_period_r};
      `LVTS_IDX_ACRATE:   rd_byte = {2'h0, ac_rate_r};
      `LVTS_IDX_S1_LO:    rd_byte = s1_start_r[7:0];
      `LVTS_IDX_S1_HI:    rd_byte = s1_start_r[15:8];
      `LVTS_IDX_S2_LO:    rd_byte = s2_start_r[7:0];
      `LVTS_IDX_S2_HI:    rd_byte = s2_start_r[15:8];
      `LVTS_IDX_TOPBIT:   rd_byte = {7'h00, s1_top_bit_r};
      `LVTS_IDX_LOFS:     rd_byte = line_ofs_r;
      `LVTS_IDX_S1H_LO:   rd_byte = s1_height_r[7:0];
      `LVTS_IDX_S1H_HI:   rd_byte = {6'h00, s1_height_r[9:8]};
      `LVTS_IDX_IRQ_STAT: rd_byte = {6'h00, irq_stat_r};
      `LVTS_IDX_IRQ_EN:   rd_byte = {6'h00, irq_en_r};
      `LVTS_IDX_IRQ_CLR:  rd_byte = 8'h00; // write-only
      `LVTS_IDX_CTRL:     rd_byte = {5'h00, ctrl_r};
      default:            rd_ok   = 1'b0;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `LVTS_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= rd_ok ? `LVTS_RESP_OKAY : `LVTS_RESP_SLVERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
    end
  end

endmodule // lvts_top

// ### lvts_panel_model.sv
// core timing model feeding line and frame pulses
`timescale 1ns/1ps
// ==========
// pulse source
module lvts_panel_model
(
  // clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // frame shape
  input  wire       run,
  input  wire [9:0] last_line,
  input  wire [5:0] period,
  // core timing
  output reg        line_pulse,
  output reg        frame_pulse
);
  integer tick;
  integer line;
  // a line every 12 cycles; held at line 0 with no pulses while run is low
  always @(posedge aclk)
  begin
    line_pulse  <= 1'b0;
    frame_pulse <= 1'b0;
    if (!aresetn || !run)
    begin
      tick <= 0;
      line <= 0;
    end
    else if (tick == 11)
    begin
      tick        <= 0;
      line_pulse  <= 1'b1;
      line        <= (line == last_line + period) ? 0 : line + 1;
      frame_pulse <= (line == last_line + 1); // end of the first blank line
    end
    else
      tick <= tick + 1;
  end
endmodule // lvts_panel_model

// ### lvts_top_assertions.sv
// bus and timing assertions for lvts_top
`timescale 1ns/1ps
`include "lvts_defs.vh"
// ==========
// checker
module lvts_top_chk
(
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // bus
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // timing
  input wire        line_pulse,
  input wire        frame_pulse,
  input wire        ac_modulation_output,
  input wire        vblank_active
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // answers and their holding
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) // [AXI]
    else $error("read answer late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) // [AXI]
    else $error("read answer dropped");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) // [AXI]
    else $error("write answer dropped");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:2] s_axi_bvalid) // [AXI]
    else $error("write answer late");
  AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready) // [AXI]
    else $error("read taken while pending");
  AST_AR_PULSE: assert property (s_axi_arready |=> !s_axi_arready) // [AXI]
    else $error("arready longer than a cycle");
  // byte registers read with zero upper bits
  AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_R_ERR: assert property (s_axi_rvalid && s_axi_rresp == `LVTS_RESP_SLVERR |-> s_axi_rdata == 32'h0) // [AXI]
    else $error("error read carries data");
  // outputs rise only after a timing pulse
  AST_MOD: assert property ($rose(ac_modulation_output) |->
    $past(line_pulse) || $past(frame_pulse) || $past(line_pulse, 2) || $past(frame_pulse, 2))
    else $error("modulation rose without pulse");
  AST_VB: assert property ($rose(vblank_active) |-> $past(line_pulse) || $past(line_pulse, 2))
    else $error("blanking began without line pulse");
endmodule // lvts_top_chk
bind lvts_top lvts_top_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .line_pulse(line_pulse), .frame_pulse(frame_pulse), .ac_modulation_output(ac_modulation_output),
  .vblank_active(vblank_active));

// ### lvts_top_tb_top.sv
// self-checking bench for lvts_top
`timescale 1ns/1ps
`include "lvts_defs.vh"
// ==========
// bench top
module lvts_top_tb_top;
  reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, run;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata, lfsr, rd_v;
  reg  [3:0]  wstrb;
  reg  [1:0]  rsp;
  wire        awready, wready, bvalid, arready, rvalid, lp, fp, acm, vb, sel, irq;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [16:0] sa;
  wire [7:0]  lofs;
  integer     err_total, n_checks, i, k, a, b;
  integer     mdl [0:63];
  lvts_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .line_pulse(lp), .frame_pulse(fp),
    .panel_last_line(10'h3), .ac_modulation_output(acm), .vblank_active(vb), .lower_screen_sel(sel),
    .screen_start_addr(sa), .line_offset_words(lofs), .irq(irq));
  lvts_panel_model u_pan (.aclk(aclk), .aresetn(aresetn), .run(run), .last_line(10'h3),
    .period(6'h3), .line_pulse(lp), .frame_pulse(fp));
  always #12.5 aclk = ~aclk;
  // ==========
  // tasks
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
  begin
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("[FAIL] %0s exp %h seen %h", nm, exp, seen);
    end
  end
  endtask
  task wrap_up;
  begin
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  task tmo(input ok);
  begin
    if (!ok)
    begin
      chk("wait", 0, 1);
      wrap_up;
    end
  end
  endtask
  // stored writable bits of each register; zero marks unmapped, read-only or write-only
  function integer msk(input [7:0] ix);
    case (ix)
      `LVTS_IDX_VBLANK, `LVTS_IDX_ACRATE: msk = 'h3f;
      `LVTS_IDX_S1_LO, `LVTS_IDX_S1_HI, `LVTS_IDX_S2_LO, `LVTS_IDX_S2_HI: msk = 'hff;
      `LVTS_IDX_LOFS, `LVTS_IDX_S1H_LO: msk = 'hff;
      `LVTS_IDX_TOPBIT: msk = 1;
      `LVTS_IDX_S1H_HI, `LVTS_IDX_IRQ_EN: msk = 3;
      `LVTS_IDX_CTRL: msk = 7;
      default: msk = 0;
    endcase
  endfunction
  function [31:0] nxt(input [31:0] l);
    nxt = {l[30:0], 1'b0} ^ (l[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  // one write, both halves offered together
  task wr(input [7:0] ix, input [7:0] d, input [3:0] s);
    integer n;
  begin
    @(posedge aclk);
    awaddr  <= {ix[5:0], 2'b00};
    wdata   <= {24'h0, d};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    n = 0;
    // bready comes only once the answer shows, so the hold of bvalid is exercised
    do
    begin
      @(posedge aclk);
      n = n + 1;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end
    while (!(bvalid && bready) && n < 200);
    rsp = bresp;
    bready <= 1'b0;
    if (s[0]) mdl[ix[5:0]] = d & msk(ix);
    tmo(n < 200);
  end
  endtask
  task rd(input [7:0] ix);
    integer n;
  begin
    @(posedge aclk);
    araddr  <= {ix[5:0], 2'b00};
    arvalid <= 1'b1;
    n = 0;
    // rready comes only once the answer shows, so the hold of rvalid is exercised
    do
    begin
      @(posedge aclk);
      n = n + 1;
      if (arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end
    while (!(rvalid && rready) && n < 200);
    rd_v = rdata;
    rsp = rresp;
    rready <= 1'b0;
    tmo(n < 200);
  end
  endtask
  task rc(input [7:0] ix, input [31:0] e);
  begin
    rd(ix);
    chk("rdata", rd_v, e);
    chk("rresp", rsp, `LVTS_RESP_OKAY);
  end
  endtask
  // wait for a line pulse, then let outputs settle
  task lw;
    integer n;
  begin
    n = 0;
    do
    begin
      @(posedge aclk);
      n = n + 1;
    end
    while (!lp && n < 200);
    tmo(n < 200);
    repeat (3) @(posedge aclk);
  end
  endtask
  // pulses between two toggles of the modulation output
  task gap(output integer nl, output integer nf);
    reg m;
    integer n;
  begin
    n = 0;
    nl = 0;
    nf = 0;
    for (k = 0; k < 2; k++)
    begin
      m = acm;
      while (acm === m && n < 2000)
      begin
        @(posedge aclk);
        n = n + 1;
        nl = nl + (k & lp);
        nf = nf + (k & fp);
      end
    end
    tmo(n < 2000);
  end
  endtask
  // ==========
  // main sequence
  initial
  begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, run} = 8'h0;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    err_total = 0;
    n_checks = 0;
    lfsr = 32'hafb4;
    for (i = 0; i < 64; i++) mdl[i] = 0;
    mdl[`LVTS_IDX_CTRL] = `LVTS_RST_CTRL;
    mdl[`LVTS_IDX_S1H_LO] = `LVTS_RST_S1H & 'hff;
    mdl[`LVTS_IDX_S1H_HI] = `LVTS_RST_S1H >> 8;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 10; i < 36; i++) if (msk(i[7:0]) != 0) rc(i[7:0], mdl[i]);
    $display("test reset values done");
    // random values; a write with no strobe changes nothing
    for (i = 10; i < 35; i++)
      if (msk(i[7:0]) != 0)
      begin
        lfsr = nxt(lfsr);
        wr(i[7:0], lfsr[7:0], 4'h1);
        wr(i[7:0], ~lfsr[7:0], 4'h0);
        rc(i[7:0], mdl[i]);
      end
    wr(8'h30, 8'h5a, 4'h1);
    chk("bresp", rsp, `LVTS_RESP_SLVERR); // [AXI]
    rd(8'h30);
    chk("rresp", rsp, `LVTS_RESP_SLVERR); // [AXI]
    $display("test registers done");
    // landscape then rotated start address and offset
    for (k = 0; k < 2; k++)
    begin
      wr(`LVTS_IDX_CTRL, {6'h1, k[0]}, 4'h1);
      repeat (2) @(posedge aclk);
      a = (k * mdl[`LVTS_IDX_TOPBIT] << 16) + (mdl[`LVTS_IDX_S1_HI] << 8) + mdl[`LVTS_IDX_S1_LO];
      chk("start", sa, a);
      chk("offset", lofs, k ? 0 : mdl[`LVTS_IDX_LOFS]);
      chk("sel", sel, 0);
    end
    $display("test addresses done");
    // two frames: three blank lines, screen two on lines 2 and 3
    wr(`LVTS_IDX_S1H_LO, 8'h1, 4'h1);
    wr(`LVTS_IDX_S1H_HI, 8'h0, 4'h1);
    wr(`LVTS_IDX_VBLANK, 8'h3, 4'h1); // set while the counter is stopped
    wr(`LVTS_IDX_CTRL, 8'h6, 4'h1);
    run <= 1'b1;
    a = 0;
    b = 0;
    for (i = 0; i < 14; i++)
    begin
      lw;
      // seven-line frame: lines 0 to 3 active, then three blank lines
      k = (i + 1) % 7;
      chk("vb", vb, k > 3);
      chk("sel", sel, k == 2 || k == 3);
      a = a + vb;
      b = b + (!vb & sel);
      k = (k == 2 || k == 3) ? (mdl[`LVTS_IDX_S2_HI] << 8) + mdl[`LVTS_IDX_S2_LO] :
        (mdl[`LVTS_IDX_S1_HI] << 8) + mdl[`LVTS_IDX_S1_LO];
      chk("split start", sa, k);
    end
    chk("blank lines", a, 6);
    chk("lower lines", b, 4);
    for (k = 0; k < 2; k++)
    begin
      i = 0;
      while (vb !== !k && i < 200)
      begin
        @(posedge aclk);
        i = i + 1;
      end
      tmo(i < 200);
      rc(`LVTS_IDX_VBLANK, k ? 3 : 'h83);
    end
    $display("test blanking done");
    // modulation rates, then an active panel
    wr(`LVTS_IDX_ACRATE, 8'h2, 4'h1);
    gap(a, b);
    chk("mod lines", a, 3);
    wr(`LVTS_IDX_ACRATE, 8'h0, 4'h1);
    gap(a, b);
    chk("mod frames", b, 1);
    wr(`LVTS_IDX_CTRL, 8'h4, 4'h1);
    a = 0;
    for (i = 0; i < 200; i++) @(posedge aclk) a = a + acm;
    chk("mod active", a, 0);
    $display("test modulation done");
    // interrupt raised, cleared, then masked
    wr(`LVTS_IDX_IRQ_EN, 8'h2, 4'h1);
    wr(`LVTS_IDX_IRQ_CLR, 8'h3, 4'h1);
    for (k = 0; k < 2; k++)
    begin
      for (i = 0; i < 8; i++) lw;
      run <= 1'b0;
      rd(`LVTS_IDX_IRQ_STAT);
      chk("stat", rd_v, 3); // [IRQ]
      chk("irq", irq, !k); // [IRQ]
      wr(`LVTS_IDX_IRQ_CLR, 8'h3, 4'h1);
      rc(`LVTS_IDX_IRQ_STAT, 0); // [IRQ]
      chk("irq clr", irq, 0); // [IRQ]
      wr(`LVTS_IDX_IRQ_EN, 8'h0, 4'h1);
      run <= 1'b1;
    end
    $display("test interrupt done");
    wrap_up;
  end
endmodule // lvts_top_tb_top
